// ==== core/sbr_majority_vote.sv ====
// Purpose: three-sample majority decision on the receive line
// Assumes: rxLevel already synchronised to clk
// Notes:   single mode passes the one sample straight through
`timescale 1ns/10ps
module sbr_majority_vote
   import sbr_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // samples
   input  wire logic rxLevel,
   input  wire logic sampleStb,
   input  wire logic lastStb,
   input  wire logic single,
   // decision
   output logic      voteBit,
   output logic      voteValid
);
   logic [1:0] hist_q;
   logic [1:0] hist_d;
   logic       vote_q;
   logic       vote_d;
   logic       valid_q;
   logic       valid_d;

   always_comb
   begin
      hist_d  = hist_q;
      vote_d  = vote_q;
      valid_d = 1'b0;
      if (sampleStb)
      begin
         hist_d = {hist_q[0], rxLevel};
         if (lastStb)
         begin
            // two of three decide the level
            vote_d = single ? rxLevel :
                     (hist_q[1] & hist_q[0]) | (hist_q[1] & rxLevel) |
                     (hist_q[0] & rxLevel);
            valid_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hist_q  <= 2'h3;
         vote_q  <= 1'b1;
         valid_q <= 1'b0;
      end
      else
      begin
         hist_q  <= hist_d;
         vote_q  <= vote_d;
         valid_q <= valid_d;
      end
   end

   assign voteBit   = vote_q;
   assign voteValid = valid_q;
endmodule

// ==== core/sbr_pkg.sv ====
// Purpose: constants for the serial bit-rate generator and receive sampling
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes:   register offsets are byte addresses
// Contract
// - divider counts every system clock edge
// - three receive samples per bit, majority vote (client mode: one sample per external clock edge, no vote; the code samples on rising edges only)
// - async 8-bit slow: clock / (64 (n+1))
// - async 8-bit fast: clock / (16 (n+1))
// - async 16-bit slow: clock / (16 (n+1))
// - synchronous: clock / (4 (n+1)), ignore speed
// - divisor is high byte over low byte
// - 8-bit divider ignores the high byte
// - divisor write clears the divider timer
// - rates only when generating own clock
package sbr_pkg;
   localparam int CLK_HZ = 40_000_000;

   // register byte offsets
   localparam logic [7:0] OFS_TX_CTRL   = 8'h00;
   localparam logic [7:0] OFS_RX_CTRL   = 8'h04;
   localparam logic [7:0] OFS_BAUD_CTRL = 8'h08;
   localparam logic [7:0] OFS_DIV_HIGH  = 8'h0c;
   localparam logic [7:0] OFS_DIV_LOW   = 8'h10;
   localparam logic [7:0] OFS_RATE_STAT = 8'h14;

   // reset values and writable masks
   localparam logic [7:0] RST_TX_CTRL   = 8'h02;
   localparam logic [7:0] RST_RX_CTRL   = 8'h00;
   localparam logic [7:0] RST_BAUD_CTRL = 8'h40;
   localparam logic [7:0] RST_DIV       = 8'h00;
   localparam logic [7:0] WM_TX_CTRL    = 8'hfd;
   localparam logic [7:0] WM_RX_CTRL    = 8'hf8;
   localparam logic [7:0] WM_BAUD_CTRL  = 8'hbb;

   // field positions
   localparam int BIT_CLOCK_SOURCE_SELECT = 7;
   localparam int BIT_SYNC_MODE           = 4;
   localparam int BIT_HIGH_SPEED_SELECT   = 2;
   localparam int BIT_PORT_ENABLE         = 7;
   localparam int BIT_WIDE_DIVIDER_SELECT = 3;
   localparam int BIT_STAT_RX_LEVEL       = 0;
   localparam int BIT_STAT_CLK_LEVEL      = 1;
   localparam int BIT_STAT_RUNNING        = 2;

   // divider ticks per bit
   localparam int PRESCALE_SLOW = 64;
   localparam int PRESCALE_MID  = 16;
   localparam int PRESCALE_FAST = 4;
   localparam logic [5:0] LAST_SLOW = 6'(PRESCALE_SLOW - 1);
   localparam logic [5:0] LAST_MID  = 6'(PRESCALE_MID - 1);
   localparam logic [5:0] LAST_FAST = 6'(PRESCALE_FAST - 1);
   localparam logic [5:0] HALF_SLOW = 6'(PRESCALE_SLOW / 2);
   localparam logic [5:0] HALF_MID  = 6'(PRESCALE_MID / 2);
   localparam logic [5:0] HALF_FAST = 6'(PRESCALE_FAST / 2);
   localparam logic [5:0] PRE_ONE   = 6'h01;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== core/sbr_rate_gen.sv ====
// Purpose: bit-rate divider, receive sampling and AXI4-Lite registers
// Assumes: one write and one read outstanding at most
// Notes:   the divisor pair must be reprogrammed by software whenever the
//          system clock frequency changes; the divider cannot tell
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module sbr_rate_gen
   import sbr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // axi4-lite write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   // axi4-lite write data
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // axi4-lite write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // axi4-lite read address
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   // axi4-lite read data
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // serial pins
   input  wire logic        rxPin,
   input  wire logic        clkPinIn,
   output logic             clkPinOut,
   output logic             clkPinOe_b,
   // to shift logic
   output logic             bitTick,
   output logic             rxBit,
   output logic             rxBitValid
);
   // register file
   logic [7:0]  txCtrl_q, txCtrl_d;
   logic [7:0]  rxCtrl_q, rxCtrl_d;
   logic [7:0]  baudCtrl_q, baudCtrl_d;
   logic [7:0]  divHigh_q, divHigh_d;
   logic [7:0]  divLow_q, divLow_d;
   logic        divWrite;
   // bus slave state
   logic        awHave_q, awHave_d;
   logic [7:0]  awAddr_q, awAddr_d;
   logic        wHave_q, wHave_d;
   logic [7:0]  wData_q, wData_d;
   logic        wLane_q, wLane_d;
   logic        awReady_q, awReady_d;
   logic        wReady_q, wReady_d;
   logic        bValid_q, bValid_d;
   logic [1:0]  bResp_q, bResp_d;
   logic        arReady_q, arReady_d;
   logic        rValid_q, rValid_d;
   logic [31:0] rData_q, rData_d;
   logic [1:0]  rResp_q, rResp_d;
   logic        doWrite;
   // divider and pins
   logic [15:0] divCnt_q, divCnt_d;
   logic [5:0]  preCnt_q, preCnt_d;
   logic        tick_q, tick_d;
   logic        clkOut_q, clkOut_d;
   logic        clkOeB_q, clkOeB_d;
   logic [1:0]  rxSync_q, ckSync_q;
   logic        ckPrev_q;
   logic [15:0] divisor;
   logic [5:0]  preLast, preHalf;
   logic        portOn, syncMode, hostMode, clientMode, generating;
   logic        divTick, sampleStb, lastStb, extEdge;

   // mode decode
   always_comb
   begin
      portOn     = rxCtrl_q[BIT_PORT_ENABLE];
      syncMode   = txCtrl_q[BIT_SYNC_MODE];
      hostMode   = syncMode & txCtrl_q[BIT_CLOCK_SOURCE_SELECT];
      clientMode = syncMode & ~txCtrl_q[BIT_CLOCK_SOURCE_SELECT];
      generating = portOn & ~clientMode;
      if (baudCtrl_q[BIT_WIDE_DIVIDER_SELECT])
         divisor = {divHigh_q, divLow_q};
      else
         divisor = {8'h00, divLow_q};
      if (syncMode)
      begin
         preLast = LAST_FAST;
         preHalf = HALF_FAST;
      end
      else if (baudCtrl_q[BIT_WIDE_DIVIDER_SELECT]
               & txCtrl_q[BIT_HIGH_SPEED_SELECT])
      begin
         preLast = LAST_FAST;
         preHalf = HALF_FAST;
      end
      else if (baudCtrl_q[BIT_WIDE_DIVIDER_SELECT]
               | txCtrl_q[BIT_HIGH_SPEED_SELECT])
      begin
         preLast = LAST_MID;
         preHalf = HALF_MID;
      end
      else
      begin
         preLast = LAST_SLOW;
         preHalf = HALF_SLOW;
      end
   end

   // divider: n+1 clocks per tick, then prescale ticks per bit
   always_comb
   begin
      divTick  = generating & (divCnt_q == divisor);
      divCnt_d = divCnt_q + 16'h0001;
      preCnt_d = preCnt_q;
      if (divTick)
      begin
         divCnt_d = 16'h0000;
         preCnt_d = (preCnt_q >= preLast) ? 6'h00 : preCnt_q + PRE_ONE;
      end
      // old count must not delay the new rate
      if (divWrite | ~generating)
      begin
         divCnt_d = 16'h0000;
         preCnt_d = 6'h00;
      end
      extEdge   = clientMode & portOn & ckSync_q[1] & ~ckPrev_q;
      tick_d    = (divTick & (preCnt_q == preLast)) | extEdge;
      sampleStb = (divTick & (preCnt_q >= preHalf - PRE_ONE)
                   & (preCnt_q <= preHalf + PRE_ONE)) | extEdge;
      lastStb   = (divTick & (preCnt_q == preHalf + PRE_ONE)) | extEdge;
      clkOeB_d  = ~(portOn & hostMode);
      clkOut_d  = portOn & hostMode & (preCnt_q >= preHalf);
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         divCnt_q <= 16'h0000;
         preCnt_q <= 6'h00;
         tick_q   <= 1'b0;
         clkOut_q <= 1'b0;
         clkOeB_q <= 1'b1;
         rxSync_q <= 2'h3;
         ckSync_q <= 2'h0;
         ckPrev_q <= 1'b0;
      end
      else
      begin
         divCnt_q <= divCnt_d;
         preCnt_q <= preCnt_d;
         tick_q   <= tick_d;
         clkOut_q <= clkOut_d;
         clkOeB_q <= clkOeB_d;
         rxSync_q <= {rxSync_q[0], rxPin};
         ckSync_q <= {ckSync_q[0], clkPinIn};
         ckPrev_q <= ckSync_q[1];
      end
   end

   sbr_majority_vote u_vote (
      .clk       (clk),
      .rst_b     (rst_b),
      .rxLevel   (rxSync_q[1]),
      .sampleStb (sampleStb),
      .lastStb   (lastStb),
      .single    (clientMode),
      .voteBit   (rxBit),
      .voteValid (rxBitValid)
   );

   // write side of the bus slave
   always_comb
   begin
      doWrite  = awHave_q & wHave_q & ~bValid_q;
      awHave_d = awHave_q;
      awAddr_d = awAddr_q;
      wHave_d  = wHave_q;
      wData_d  = wData_q;
      wLane_d  = wLane_q;
      bValid_d = bValid_q & ~bready;
      bResp_d  = bResp_q;
      if (awvalid & awReady_q)
      begin
         awHave_d = 1'b1;
         awAddr_d = awaddr;
      end
      if (wvalid & wReady_q)
      begin
         wHave_d = 1'b1;
         wData_d = wdata[7:0];
         wLane_d = wstrb[0];
      end
      txCtrl_d   = txCtrl_q;
      rxCtrl_d   = rxCtrl_q;
      baudCtrl_d = baudCtrl_q;
      divHigh_d  = divHigh_q;
      divLow_d   = divLow_q;
      divWrite   = 1'b0;
      if (doWrite)
      begin
         awHave_d = 1'b0;
         wHave_d  = 1'b0;
         bValid_d = 1'b1;
         bResp_d  = RESP_OKAY;
         case (awAddr_q)
            OFS_TX_CTRL:
               if (wLane_q)
                  txCtrl_d = (txCtrl_q & ~WM_TX_CTRL)
                             | (wData_q & WM_TX_CTRL);
            OFS_RX_CTRL:
               if (wLane_q)
                  rxCtrl_d = (rxCtrl_q & ~WM_RX_CTRL)
                             | (wData_q & WM_RX_CTRL);
            OFS_BAUD_CTRL:
               if (wLane_q)
                  baudCtrl_d = (baudCtrl_q & ~WM_BAUD_CTRL)
                               | (wData_q & WM_BAUD_CTRL);
            OFS_DIV_HIGH:
               if (wLane_q)
               begin
                  divHigh_d = wData_q;
                  divWrite  = 1'b1;
               end
            OFS_DIV_LOW:
               if (wLane_q)
               begin
                  divLow_d = wData_q;
                  divWrite = 1'b1;
               end
            OFS_RATE_STAT:
               bResp_d = RESP_OKAY;
            default:
               bResp_d = RESP_SLVERR;
         endcase
      end
      awReady_d = ~awHave_d;
      wReady_d  = ~wHave_d;
   end

   // read side of the bus slave
   always_comb
   begin
      rValid_d  = rValid_q & ~rready;
      rData_d   = rData_q;
      rResp_d   = rResp_q;
      if (arvalid & arReady_q)
      begin
         rValid_d = 1'b1;
         rResp_d  = RESP_OKAY;
         rData_d  = 32'h0000_0000;
         case (araddr)
            OFS_TX_CTRL:   rData_d[7:0] = txCtrl_q;
            OFS_RX_CTRL:   rData_d[7:0] = rxCtrl_q;
            OFS_BAUD_CTRL: rData_d[7:0] = baudCtrl_q;
            OFS_DIV_HIGH:  rData_d[7:0] = divHigh_q;
            OFS_DIV_LOW:   rData_d[7:0] = divLow_q;
            OFS_RATE_STAT:
            begin
               rData_d[BIT_STAT_RX_LEVEL]  = rxBit;
               rData_d[BIT_STAT_CLK_LEVEL] = clkOut_q;
               rData_d[BIT_STAT_RUNNING]   = generating;
            end
            default:       rResp_d = RESP_SLVERR;
         endcase
      end
      // one read in flight: no new address until data is taken
      arReady_d = ~rValid_d;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         txCtrl_q   <= RST_TX_CTRL;
         rxCtrl_q   <= RST_RX_CTRL;
         baudCtrl_q <= RST_BAUD_CTRL;
         divHigh_q  <= RST_DIV;
         divLow_q   <= RST_DIV;
         awHave_q   <= 1'b0;
         awAddr_q   <= 8'h00;
         wHave_q    <= 1'b0;
         wData_q    <= 8'h00;
         wLane_q    <= 1'b0;
         awReady_q  <= 1'b0;
         wReady_q   <= 1'b0;
         bValid_q   <= 1'b0;
         bResp_q    <= RESP_OKAY;
         arReady_q  <= 1'b0;
         rValid_q   <= 1'b0;
         rData_q    <= 32'h0000_0000;
         rResp_q    <= RESP_OKAY;
      end
      else
      begin
         txCtrl_q   <= txCtrl_d;
         rxCtrl_q   <= rxCtrl_d;
         baudCtrl_q <= baudCtrl_d;
         divHigh_q  <= divHigh_d;
         divLow_q   <= divLow_d;
         awHave_q   <= awHave_d;
         awAddr_q   <= awAddr_d;
         wHave_q    <= wHave_d;
         wData_q    <= wData_d;
         wLane_q    <= wLane_d;
         awReady_q  <= awReady_d;
         wReady_q   <= wReady_d;
         bValid_q   <= bValid_d;
         bResp_q    <= bResp_d;
         arReady_q  <= arReady_d;
         rValid_q   <= rValid_d;
         rData_q    <= rData_d;
         rResp_q    <= rResp_d;
      end
   end

   assign awready    = awReady_q;
   assign wready     = wReady_q;
   assign bvalid     = bValid_q;
   assign bresp      = bResp_q;
   assign arready    = arReady_q;
   assign rvalid     = rValid_q;
   assign rdata      = rData_q;
   assign rresp      = rResp_q;
   assign bitTick    = tick_q;
   assign clkPinOut  = clkOut_q;
   assign clkPinOe_b = clkOeB_q;
endmodule

// ==== tb/sbr_rate_gen_properties.sv ====
// Purpose: port-level checks for the rate generator
// Assumes: bound to sbr_rate_gen, one clock domain
// Notes:   receive check only trusts a line quiet for 1000+ cycles
`timescale 1ns/10ps
module sbr_rate_gen_properties
   import sbr_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // register bus
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   // serial side
   input wire logic        rxPin,
   input wire logic        bitTick,
   input wire logic        rxBit,
   input wire logic        rxBitValid
);
   logic [11:0] quiet_q;
   logic [11:0] quiet_d;
   logic        rxOld_q;
   // saturating count of cycles since the line last moved
   always_comb
   begin
      quiet_d = quiet_q + {11'h0, quiet_q != 12'hfff};
      if (rxPin != rxOld_q)
         quiet_d = 12'h000;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         quiet_q <= 12'h000;
         rxOld_q <= 1'b1;
      end
      else
      begin
         quiet_q <= quiet_d;
         rxOld_q <= rxPin;
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_tick_pulse: assert property (bitTick |=> !bitTick)
      else $error("bit tick wider than one cycle");
   chk_vote_pulse: assert property (rxBitValid |=> !rxBitValid)
      else $error("vote strobe wider than one cycle");
   chk_vote_level: assert property (rxBitValid && quiet_q > 12'd1000
      |-> rxBit == rxPin)
      else $error("voted bit differs from steady line");
   chk_write_answer: assert property (awvalid && awready && wvalid
      && wready |-> ##[1:2] bvalid)
      else $error("write response missing");
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   chk_read_refuse: assert property (rvalid |-> !arready)
      else $error("read address taken while data pending");
   chk_rdata_hold: assert property (rvalid && !rready
      |=> rvalid && $stable(rdata))
      else $error("read data dropped before taken");
   chk_bresp_hold: assert property (bvalid && !bready
      |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");
   chk_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule

// ==== tb/sbr_rate_gen_tb.sv ====
// Purpose: register and bit-rate bench for the rate generator
// Assumes: 40 MHz clock, master offers address and data together
// Notes:   periods measured between two consecutive bit ticks
`timescale 1ns/10ps
module sbr_rate_gen_tb;
   import sbr_pkg::*;
   logic        clk     = 1'b0;
   logic        rst_b   = 1'b0;
   logic        awvalid = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic        wvalid  = 1'b0;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  wstrb   = 4'h0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic [7:0]  araddr  = 8'h00;
   logic        rready  = 1'b0;
   logic        rxCmd   = 1'b1;
   logic        extOn   = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata, d;
   logic        rxPin, extClk, clkPinOut, clkPinOe_b, clkWire;
   logic        bitTick, rxBit, rxBitValid;
   int          miscompares = 0;
   int          samplesChecked = 0;
   int          i, n;
   logic [7:0]  rstv [5] = '{RST_TX_CTRL, RST_RX_CTRL, RST_BAUD_CTRL,
                             RST_DIV, RST_DIV};
   // tx, baud, high, low divisor bytes per mode
   logic [31:0] mt [7] = '{32'h00400001, 32'h04400002, 32'h00480100,
      32'h04480102, 32'h94400003, 32'h90480000, 32'h00400102};
   int          per [7] = '{128, 48, 4112, 1036, 16, 4, 192};
   always #12.5 clk = ~clk;
   // the pin carries whoever enables its driver
   assign clkWire = !clkPinOe_b ? clkPinOut : extClk;
   sbr_rate_gen u_sbr_rate_gen (.clk(clk), .rst_b(rst_b),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .rxPin(rxPin), .clkPinIn(clkWire), .clkPinOut(clkPinOut),
      .clkPinOe_b(clkPinOe_b), .bitTick(bitTick), .rxBit(rxBit),
      .rxBitValid(rxBitValid));
   sbr_shift_partner u_sbr_shift_partner (.clk(clk), .rst_b(rst_b),
      .rxLevel(rxCmd), .extClkOn(extOn), .rxLine(rxPin),
      .clkLine(extClk));
   task wrap_up;
      if (miscompares == 0 && samplesChecked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task cmp_word(input logic [31:0] g, input logic [31:0] e);
      samplesChecked++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task cmp_count(input int g, input int e);
      samplesChecked++;
      if (g != e)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task guard(input int k, input int lim);
      if (k >= lim)
      begin
         miscompares++;
         wrap_up();
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] v,
                         input logic [1:0] e);
      int k;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= {24'h0, v};
      wstrb   <= 4'h1;
      bready  <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      guard(k, 50);
      bready <= 1'b0;
      cmp_word({30'h0, bresp}, {30'h0, e});
   endtask
   // late holds rready off until data stands, so the hold checks fire
   task automatic axi_rd(input logic [7:0] a, input logic late = 1'b0);
      int k;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= !late;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid === 1'b1 && rready === 1'b1) break;
         if (rvalid === 1'b1) rready <= 1'b1;
      end
      guard(k, 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic wait_tick;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (bitTick !== 1'b1 && n < 9000);
      guard(n, 9000);
   endtask
   task automatic set_rate(input logic [31:0] m);
      axi_wr(OFS_TX_CTRL, m[31:24], RESP_OKAY);
      axi_wr(OFS_BAUD_CTRL, m[23:16], RESP_OKAY);
      axi_wr(OFS_DIV_HIGH, m[15:8], RESP_OKAY);
      axi_wr(OFS_DIV_LOW, m[7:0], RESP_OKAY);
   endtask
   task automatic check_rx(input logic v);
      rxCmd <= v;
      repeat (1100) @(posedge clk);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rxBitValid !== 1'b1 && n < 2000);
      guard(n, 2000);
      cmp_word({31'h0, rxBit}, {31'h0, v});
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 5; i++)
      begin
         axi_rd(8'(i * 4));
         cmp_word(d, {24'h0, rstv[i]});
         cmp_word({30'h0, r}, {30'h0, RESP_OKAY});
      end
      axi_rd(8'h20);
      cmp_word({30'h0, r}, {30'h0, RESP_SLVERR});
      axi_wr(8'h20, 8'hff, RESP_SLVERR);
      // port still off: divider must stay silent
      n = 0;
      repeat (300)
      begin
         @(posedge clk);
         n += int'(bitTick === 1'b1);
      end
      cmp_count(n, 0);
      axi_wr(OFS_RX_CTRL, 8'h80, RESP_OKAY);
      for (i = 0; i < 7; i++)
      begin
         set_rate(mt[i]);
         wait_tick();
         wait_tick();
         cmp_count(n, per[i]);
         if (mt[i][28]) cmp_word({31'h0, clkPinOe_b}, 32'h0);
         // host clock is high half of every bit; 16 cycles span whole bits
         n = 0;
         repeat (16)
         begin
            @(posedge clk);
            n += int'(clkPinOut === 1'b1);
         end
         cmp_count(n, mt[i][28] ? 8 : 0);
      end
      // restart mid-count: the old count must not survive
      set_rate(32'h00400003);
      wait_tick();
      repeat (100) @(posedge clk);
      axi_wr(OFS_DIV_LOW, 8'h03, RESP_OKAY);
      wait_tick();
      cmp_count(int'(n > 240 && n < 260), 1);
      check_rx(1'b0);
      check_rx(1'b1);
      // status is read-only: the write must leave it alone
      axi_wr(OFS_RATE_STAT, 8'h00, RESP_OKAY);
      axi_rd(OFS_RATE_STAT, 1'b1);
      cmp_word(d, 32'h0000_0005);
      extOn <= 1'b1;
      set_rate(32'h10400000);
      wait_tick();
      wait_tick();
      cmp_count(n, 20);
      cmp_word({31'h0, clkPinOe_b}, 32'h1);
      axi_rd(OFS_RATE_STAT);
      cmp_word(d, 32'h0000_0001);
      wrap_up();
   end
endmodule
bind sbr_rate_gen sbr_rate_gen_properties u_sbr_rate_gen_properties (
   .clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .rxPin(rxPin), .bitTick(bitTick),
   .rxBit(rxBit), .rxBitValid(rxBitValid));

// ==== tb/sbr_shift_partner.sv ====
// Purpose: far-side serial lines for the rate generator
// Assumes: bench sets the receive level and clock enable
// Notes:   external clock stands low while disabled
`timescale 1ns/10ps
module sbr_shift_partner
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // bench commands
   input wire logic rxLevel,
   input wire logic extClkOn,
   // serial lines
   output logic     rxLine,
   output logic     clkLine
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       clk_q;
   logic       clk_d;
   logic       rx_q;
   // client clock: toggles every 10 system clocks
   always_comb
   begin
      cnt_d = (extClkOn && cnt_q != 4'h9) ? cnt_q + 4'h1 : 4'h0;
      clk_d = extClkOn && (clk_q ^ (cnt_q == 4'h9));
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_q <= 4'h0;
         clk_q <= 1'b0;
         rx_q  <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_d;
         clk_q <= clk_d;
         rx_q  <= rxLevel;
      end
   end
   assign rxLine  = rx_q;
   assign clkLine = clk_q;
endmodule
